// ### hdl/pre_engine.sv
// Packed ring engine: descriptor fetch, used write-back, notification
`timescale 1ns/1ps
module pre_engine (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_awaddr,
	input wire logic s_awvalid,
	output logic s_awready,
	input wire logic [31:0] s_wdata,
	input wire logic [3:0] s_wstrb,
	input wire logic s_wvalid,
	output logic s_wready,
	output logic [1:0] s_bresp,
	output logic s_bvalid,
	input wire logic s_bready,
	input wire logic [7:0] s_araddr,
	input wire logic s_arvalid,
	output logic s_arready,
	output logic [31:0] s_rdata,
	output logic [1:0] s_rresp,
	output logic s_rvalid,
	input wire logic s_rready,
	output pre_pkg::pre_mem_req_t mem_req,
	output logic mem_req_valid,
	input wire logic mem_req_ready,
	input wire logic mem_rsp_valid,
	input wire logic [127:0] mem_rdata,
	output pre_pkg::pre_desc_t work_desc,
	output logic work_head,
	output logic work_valid,
	input wire logic work_ready,
	input wire pre_pkg::pre_done_t done,
	input wire logic done_valid,
	output logic done_ready,
	output logic used_notify
);

	// Software registers
	logic ctrl_en;
	logic [31:0] ring_base;
	logic [15:0] ring_size;
	logic [15:0] list_cap;
	logic [31:0] drv_area;
	logic [31:0] dev_area;
	logic [31:0] dev_event;
	logic dev_pend;
	logic dev_take;

	// Write channel holding registers
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic [31:0] wr_new;

	// Engine state
	pre_pkg::pre_state_t state;
	logic [pre_pkg::POS_W-1:0] fpos;
	logic [pre_pkg::POS_W-1:0] upos;
	logic fwrap;
	logic uwrap;
	logic err;
	logic [15:0] list_cnt;
	logic [15:0] used_cnt;
	logic [pre_pkg::POS_W-1:0] ev_pos;
	logic ev_wrap;
	pre_pkg::pre_done_t cmp;
	logic tbl_we;
	logic [pre_pkg::TAG_W-1:0] tbl_waddr;
	logic [15:0] tbl_wdata;
	logic [15:0] tbl_rdata;

	// Derived values
	pre_pkg::pre_desc_t rd_desc;
	logic [15:0] cap_eff;
	logic [16:0] list_next;
	logic [16:0] used_sum;
	logic [31:0] evt_word;
	logic [1:0] evt_flags;

	assign rd_desc = pre_pkg::pre_desc_t'(mem_rdata);
	assign evt_word = mem_rdata[31:0];
	assign evt_flags = evt_word[pre_pkg::EVT_FLAGS_LSB +: 2];

	// A zero cap falls back to the ring size
	assign cap_eff = (list_cap == 16'h0000) ? ring_size : list_cap;
	assign list_next = {1'b0, list_cnt} + 17'h00001;

	// A zero list length from the table: still skip one entry
	assign used_sum = {2'b00, upos} + ((used_cnt == 16'h0000) ? 17'h00001 : {1'b0, used_cnt});

	// Byte address of a ring slot
	function automatic logic [31:0] slot_addr(input logic [pre_pkg::POS_W-1:0] p);
		return ring_base + {13'h0000, p, 4'h0};
	endfunction : slot_addr

	// Register read value and decode hit
	function automatic logic [31:0] rd_word(input logic [7:0] a);
		logic [31:0] v;
		v = 32'h0000_0000;
		unique case (a)
			pre_pkg::REG_CTRL: v = {31'h0000_0000, ctrl_en};
			pre_pkg::REG_RING_BASE: v = ring_base;
			pre_pkg::REG_RING_SIZE: v = {16'h0000, ring_size};
			pre_pkg::REG_LIST_CAP: v = {16'h0000, list_cap};
			pre_pkg::REG_DRV_AREA: v = drv_area;
			pre_pkg::REG_DEV_AREA: v = dev_area;
			pre_pkg::REG_DEV_EVENT: v = dev_event;
			pre_pkg::REG_STATUS: v = {14'h0000, err, uwrap, fwrap, fpos};
			pre_pkg::REG_USED_POS: v = {17'h00000, upos};
			default: v = 32'h0000_0000;
		endcase
		return v;
	endfunction : rd_word

	function automatic logic rd_hit(input logic [7:0] a);
		return (a <= pre_pkg::REG_USED_POS) && (a[1:0] == 2'h0);
	endfunction : rd_hit

	// Byte-lane merge of a write into the current value
	function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] s);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (s[i]) begin
				r[8*i +: 8] = d[8*i +: 8];
			end
		end
		return r;
	endfunction : wmerge

	// Offered only when offered marker matches our wrap and consumed does not
	function automatic logic is_offered(input logic [15:0] f, input logic w);
		return (f[pre_pkg::OFFERED_MARKER_BIT] == w) && (f[pre_pkg::CONSUMED_MARKER_BIT] != w);
	endfunction : is_offered

	function automatic pre_pkg::pre_mem_req_t mk_req(input logic wr, input logic wd,
		input logic [31:0] a, input logic [127:0] d);
		pre_pkg::pre_mem_req_t r;
		r.write = wr;
		r.word = wd;
		r.addr = a;
		r.wdata = d;
		return r;
	endfunction : mk_req

	// Used descriptor image: markers equal our wrap, address left zero
	function automatic logic [127:0] mk_used(input pre_pkg::pre_done_t c, input logic w);
		pre_pkg::pre_desc_t u;
		u.flags = 16'h0000;
		u.flags[pre_pkg::OFFERED_MARKER_BIT] = w;
		u.flags[pre_pkg::CONSUMED_MARKER_BIT] = w;
		u.flags[pre_pkg::DEVICE_WRITABLE_BIT] = c.wrote;
		u.id = c.id;
		u.len = c.wrote ? c.len : 32'h0000_0000;
		u.addr = 64'h0000_0000_0000_0000;
		return u;
	endfunction : mk_used

	assign wr_new = wmerge(rd_word(aw_addr), w_data, w_strb);

	// Write channel: address and data taken in either order, answer after both
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_awready <= 1'b1;
			s_wready <= 1'b1;
			s_bvalid <= 1'b0;
			s_bresp <= pre_pkg::RESP_OKAY;
			aw_addr <= 8'h00;
			w_data <= pre_pkg::REG_RST;
			w_strb <= 4'h0;
		end else begin
			if (s_awvalid && s_awready) begin
				aw_addr <= s_awaddr;
				s_awready <= 1'b0;
			end
			if (s_wvalid && s_wready) begin
				w_data <= s_wdata;
				w_strb <= s_wstrb;
				s_wready <= 1'b0;
			end
			if (!s_awready && !s_wready && !s_bvalid) begin
				s_bvalid <= 1'b1;
				s_bresp <= rd_hit(aw_addr) ? pre_pkg::RESP_OKAY : pre_pkg::RESP_DECERR;
			end
			if (s_bvalid && s_bready) begin
				s_bvalid <= 1'b0;
				s_awready <= 1'b1;
				s_wready <= 1'b1;
			end
		end
	end

	// Register storage; status words ignore writes
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_en <= 1'b0;
			ring_base <= pre_pkg::REG_RST;
			ring_size <= pre_pkg::RING_SIZE_RST;
			list_cap <= pre_pkg::LIST_CAP_RST;
			drv_area <= pre_pkg::REG_RST;
			dev_area <= pre_pkg::REG_RST;
			dev_event <= pre_pkg::REG_RST;
		end else if (!s_awready && !s_wready && !s_bvalid) begin
			unique case (aw_addr)
				pre_pkg::REG_CTRL: ctrl_en <= wr_new[0];
				pre_pkg::REG_RING_BASE: ring_base <= wr_new;
				pre_pkg::REG_RING_SIZE: ring_size <= wr_new[15:0];
				pre_pkg::REG_LIST_CAP: list_cap <= wr_new[15:0];
				pre_pkg::REG_DRV_AREA: drv_area <= wr_new;
				pre_pkg::REG_DEV_AREA: dev_area <= wr_new;
				pre_pkg::REG_DEV_EVENT: dev_event <= wr_new;
				default: ;
			endcase
		end
	end

	// Suppression publish request; a new write beats the engine's clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dev_pend <= 1'b0;
		end else begin
			if (dev_take) begin
				dev_pend <= 1'b0;
			end
			if (!s_awready && !s_wready && !s_bvalid && aw_addr == pre_pkg::REG_DEV_EVENT) begin
				dev_pend <= 1'b1;
			end
		end
	end

	// Read channel: one cycle from address to data
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_arready <= 1'b1;
			s_rvalid <= 1'b0;
			s_rdata <= pre_pkg::REG_RST;
			s_rresp <= pre_pkg::RESP_OKAY;
		end else if (s_arvalid && s_arready) begin
			s_arready <= 1'b0;
			s_rvalid <= 1'b1;
			s_rdata <= rd_word(s_araddr);
			s_rresp <= rd_hit(s_araddr) ? pre_pkg::RESP_OKAY : pre_pkg::RESP_DECERR;
		end else if (s_rvalid && s_rready) begin
			s_rvalid <= 1'b0;
			s_arready <= 1'b1;
		end
	end

	// List length per tag, so write-back can skip the whole list
	pre_len_mem u_len_mem (
		.aclk(aclk),
		.aresetn(aresetn),
		.we(tbl_we),
		.waddr(tbl_waddr),
		.wdata(tbl_wdata),
		.raddr(done.id[pre_pkg::TAG_W-1:0]),
		.rdata(tbl_rdata)
	);

	// Main sequencer; completions first so finished work retires promptly
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= pre_pkg::ST_IDLE;
			fpos <= '0;
			upos <= '0;
			fwrap <= pre_pkg::WRAP_RST;
			uwrap <= pre_pkg::WRAP_RST;
			err <= 1'b0;
			list_cnt <= 16'h0000;
			used_cnt <= 16'h0000;
			ev_pos <= '0;
			ev_wrap <= 1'b0;
			cmp <= '0;
			mem_req <= '0;
			mem_req_valid <= 1'b0;
			work_desc <= '0;
			work_head <= 1'b0;
			work_valid <= 1'b0;
			done_ready <= 1'b0;
			tbl_we <= 1'b0;
			tbl_waddr <= '0;
			tbl_wdata <= 16'h0000;
			used_notify <= 1'b0;
			dev_take <= 1'b0;
		end else begin
			tbl_we <= 1'b0;
			used_notify <= 1'b0;
			dev_take <= 1'b0;
			unique case (state)
				pre_pkg::ST_IDLE: begin
					if (!ctrl_en) begin
						// Disabled: positions return to the ring start
						fpos <= '0;
						upos <= '0;
						fwrap <= pre_pkg::WRAP_RST;
						uwrap <= pre_pkg::WRAP_RST;
						err <= 1'b0;
						list_cnt <= 16'h0000;
						done_ready <= 1'b0;
					end else if (done_valid && done_ready) begin
						cmp <= done;
						done_ready <= 1'b0;
						state <= pre_pkg::ST_U_LOOK;
					end else if (dev_pend) begin
						mem_req <= mk_req(1'b1, 1'b1, dev_area, {96'h0, dev_event});
						mem_req_valid <= 1'b1;
						dev_take <= 1'b1;
						done_ready <= 1'b0;
						state <= pre_pkg::ST_D_REQ;
					end else if (!err) begin
						// Poll only the next slot in ring order
						mem_req <= mk_req(1'b0, 1'b0, slot_addr(fpos), 128'h0);
						mem_req_valid <= 1'b1;
						done_ready <= 1'b0;
						state <= pre_pkg::ST_F_REQ;
					end else begin
						done_ready <= 1'b1;
					end
				end
				pre_pkg::ST_F_REQ: begin
					if (mem_req_ready) begin
						mem_req_valid <= 1'b0;
						state <= pre_pkg::ST_F_WAIT;
					end
				end
				pre_pkg::ST_F_WAIT: begin
					if (mem_rsp_valid) begin
						if (is_offered(rd_desc.flags, fwrap)) begin
							work_desc <= rd_desc;
							work_head <= (list_cnt == 16'h0000);
							work_valid <= 1'b1;
							state <= pre_pkg::ST_F_OUT;
						end else begin
							// Not offered yet: retry the same slot later
							done_ready <= ctrl_en;
							state <= pre_pkg::ST_IDLE;
						end
					end
				end
				pre_pkg::ST_F_OUT: begin
					if (work_ready) begin
						work_valid <= 1'b0;
						if ({1'b0, fpos} == ring_size - 16'h0001) begin
							fpos <= '0;
							fwrap <= ~fwrap;
						end else begin
							fpos <= fpos + 15'h0001;
						end
						if (work_desc.flags[pre_pkg::CHAIN_CONTINUE_BIT]) begin
							list_cnt <= list_next[15:0];
							if (list_next >= {1'b0, cap_eff}) begin
								err <= 1'b1;
							end
						end else begin
							// Tag sits in the last element; remember list size
							tbl_we <= 1'b1;
							tbl_waddr <= work_desc.id[pre_pkg::TAG_W-1:0];
							tbl_wdata <= list_next[15:0];
							list_cnt <= 16'h0000;
						end
						done_ready <= ctrl_en;
						state <= pre_pkg::ST_IDLE;
					end
				end
				pre_pkg::ST_U_LOOK: begin
					used_cnt <= tbl_rdata;
					ev_pos <= upos;
					ev_wrap <= uwrap;
					mem_req <= mk_req(1'b1, 1'b0, slot_addr(upos), mk_used(cmp, uwrap));
					mem_req_valid <= 1'b1;
					state <= pre_pkg::ST_U_REQ;
				end
				pre_pkg::ST_U_REQ: begin
					if (mem_req_ready) begin
						mem_req_valid <= 1'b0;
						state <= pre_pkg::ST_U_WAIT;
					end
				end
				pre_pkg::ST_U_WAIT: begin
					if (mem_rsp_valid) begin
						// Skip the rest of the list; flip past the final entry
						if (used_sum >= {1'b0, ring_size}) begin
							upos <= 15'(used_sum - {1'b0, ring_size});
							uwrap <= ~uwrap;
						end else begin
							upos <= used_sum[pre_pkg::POS_W-1:0];
						end
						mem_req <= mk_req(1'b0, 1'b1, drv_area, 128'h0);
						mem_req_valid <= 1'b1;
						state <= pre_pkg::ST_S_REQ;
					end
				end
				pre_pkg::ST_S_REQ: begin
					if (mem_req_ready) begin
						mem_req_valid <= 1'b0;
						state <= pre_pkg::ST_S_WAIT;
					end
				end
				pre_pkg::ST_S_WAIT: begin
					if (mem_rsp_valid) begin
						// Reserved code 3 is treated as disabled
						used_notify <= (evt_flags == pre_pkg::EVT_ENABLE)
							|| (evt_flags == pre_pkg::EVT_DESC
							&& evt_word[pre_pkg::POS_W-1:0] == ev_pos
							&& evt_word[pre_pkg::EVT_WRAP_BIT] == ev_wrap);
						done_ready <= ctrl_en;
						state <= pre_pkg::ST_IDLE;
					end
				end
				pre_pkg::ST_D_REQ: begin
					if (mem_req_ready) begin
						mem_req_valid <= 1'b0;
						state <= pre_pkg::ST_D_WAIT;
					end
				end
				pre_pkg::ST_D_WAIT: begin
					if (mem_rsp_valid) begin
						done_ready <= ctrl_en;
						state <= pre_pkg::ST_IDLE;
					end
				end
				default: begin
					state <= pre_pkg::ST_IDLE;
				end
			endcase
		end
	end

endmodule : pre_engine

// ### hdl/pre_len_mem.sv
// List length table indexed by buffer tag, registered read data
`timescale 1ns/1ps
module pre_len_mem (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic we,
	input wire logic [pre_pkg::TAG_W-1:0] waddr,
	input wire logic [15:0] wdata,
	input wire logic [pre_pkg::TAG_W-1:0] raddr,
	output logic [15:0] rdata
);

	logic [15:0] mem [0:(1 << pre_pkg::TAG_W)-1];

	// Storage holds no reset; a never written tag reads stale data
	always_ff @(posedge aclk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	// Read port registered so data lands one edge after the address
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rdata <= 16'h0000;
		end else begin
			rdata <= mem[raddr];
		end
	end

endmodule : pre_len_mem

// ### hdl/pre_pkg.sv
// Constants, register map and carrier types for the packed ring engine
package pre_pkg;

	// Ring geometry: at most 2^15 entries, positions are 15 bits
	localparam int unsigned POS_W = 15;
	localparam int unsigned TAG_W = 8;
	localparam logic [15:0] RING_SIZE_RST = 16'h8000;
	localparam logic [15:0] LIST_CAP_RST = 16'h0000;
	localparam logic WRAP_RST = 1'b1;

	// Register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_RING_BASE = 8'h04;
	localparam logic [7:0] REG_RING_SIZE = 8'h08;
	localparam logic [7:0] REG_LIST_CAP = 8'h0c;
	localparam logic [7:0] REG_DRV_AREA = 8'h10;
	localparam logic [7:0] REG_DEV_AREA = 8'h14;
	localparam logic [7:0] REG_DEV_EVENT = 8'h18;
	localparam logic [7:0] REG_STATUS = 8'h1c;
	localparam logic [7:0] REG_USED_POS = 8'h20;
	localparam logic [31:0] REG_RST = 32'h0000_0000;

	// AXI responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	// Descriptor flag positions
	localparam int unsigned CHAIN_CONTINUE_BIT = 0;
	localparam int unsigned DEVICE_WRITABLE_BIT = 1;
	localparam int unsigned OFFERED_MARKER_BIT = 7;
	localparam int unsigned CONSUMED_MARKER_BIT = 15;

	// Suppression word layout and event codes
	localparam int unsigned EVT_WRAP_BIT = 15;
	localparam int unsigned EVT_FLAGS_LSB = 16;
	localparam logic [1:0] EVT_ENABLE = 2'h0;
	localparam logic [1:0] EVT_DISABLE = 2'h1;
	localparam logic [1:0] EVT_DESC = 2'h2;

	// Status field positions
	localparam int unsigned ST_FWRAP_BIT = 15;
	localparam int unsigned ST_UWRAP_BIT = 16;
	localparam int unsigned ST_ERR_BIT = 17;

	// A descriptor is 16 bytes in the ring
	localparam int unsigned DESC_SHIFT = 4;

	typedef struct packed {
		logic [15:0] flags;
		logic [15:0] id;
		logic [31:0] len;
		logic [63:0] addr;
	} pre_desc_t;

	typedef struct packed {
		logic write;
		logic word;
		logic [31:0] addr;
		logic [127:0] wdata;
	} pre_mem_req_t;

	typedef struct packed {
		logic [15:0] id;
		logic [31:0] len;
		logic wrote;
	} pre_done_t;

	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_F_REQ = 4'h1,
		ST_F_WAIT = 4'h2,
		ST_F_OUT = 4'h3,
		ST_U_LOOK = 4'h4,
		ST_U_REQ = 4'h5,
		ST_U_WAIT = 4'h6,
		ST_S_REQ = 4'h7,
		ST_S_WAIT = 4'h8,
		ST_D_REQ = 4'h9,
		ST_D_WAIT = 4'ha
	} pre_state_t;

endpackage : pre_pkg

// ### testbench/pre_engine_properties.sv
// Concurrent checks on the packed ring engine ports
`timescale 1ns/1ps
module pre_engine_properties (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_awvalid,
	input wire logic s_awready,
	input wire logic s_wvalid,
	input wire logic s_wready,
	input wire logic s_bvalid,
	input wire logic s_arvalid,
	input wire logic s_arready,
	input wire logic s_rvalid,
	input wire pre_pkg::pre_mem_req_t mem_req,
	input wire logic mem_req_valid,
	input wire logic mem_req_ready,
	input wire logic mem_rsp_valid,
	input wire pre_pkg::pre_desc_t work_desc,
	input wire logic work_valid,
	input wire logic work_ready,
	input wire logic used_notify
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// A full descriptor write is always a used write-back
	logic used_wr;
	assign used_wr = mem_req_valid && mem_req.write && !mem_req.word;

	// Bus steps
	sequence s_wr_taken;
		s_awvalid && s_awready && s_wvalid && s_wready;
	endsequence
	sequence s_rd_taken;
		s_arvalid && s_arready;
	endsequence

	a_wr_answer: assert property (s_wr_taken |-> ##2 s_bvalid)
		else $error("write response late");
	a_rd_answer: assert property (s_rd_taken |=> s_rvalid)
		else $error("read data late");
	a_req_stable: assert property (mem_req_valid && !mem_req_ready |=> mem_req_valid && $stable(mem_req))
		else $error("memory request changed before taken");
	a_work_stable: assert property (work_valid && !work_ready |=> work_valid && $stable(work_desc))
		else $error("work descriptor changed before taken");
	a_work_offered: assert property (work_valid |-> work_desc.flags[7] != work_desc.flags[15])
		else $error("work handed out for an unavailable slot");
	a_fetch_after_rsp: assert property ($rose(work_valid) |-> $past(mem_rsp_valid))
		else $error("work raised without a fetch response");
	a_used_markers: assert property (used_wr |-> mem_req.wdata[127] == mem_req.wdata[119])
		else $error("used markers differ");
	a_used_addr: assert property (used_wr |-> mem_req.wdata[63:0] == 64'h0)
		else $error("used address not zero");
	a_used_len: assert property (used_wr && !mem_req.wdata[113] |-> mem_req.wdata[95:64] == 32'h0)
		else $error("used length set without data written");
	a_notify_cause: assert property (used_notify |-> $past(mem_rsp_valid) && !$past(used_notify))
		else $error("notification not a pulse after a response");
endmodule : pre_engine_properties

bind pre_engine pre_engine_properties u_props (.aclk(aclk), .aresetn(aresetn),
	.s_awvalid(s_awvalid), .s_awready(s_awready), .s_wvalid(s_wvalid), .s_wready(s_wready),
	.s_bvalid(s_bvalid), .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rvalid(s_rvalid),
	.mem_req(mem_req), .mem_req_valid(mem_req_valid), .mem_req_ready(mem_req_ready),
	.mem_rsp_valid(mem_rsp_valid), .work_desc(work_desc), .work_valid(work_valid),
	.work_ready(work_ready), .used_notify(used_notify));

// ### testbench/pre_engine_tb_top.sv
// Self-checking bench for the packed ring engine
`timescale 1ns/1ps
module pre_engine_tb_top;
	localparam logic [31:0] BASE = 32'h0000_1000;
	localparam int RSZ = 4;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] s_awaddr = 8'h00, s_araddr = 8'h00;
	logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0, s_arvalid = 1'b0, s_rready = 1'b0;
	logic [31:0] s_wdata = 32'h0;
	logic [3:0] s_wstrb = 4'hf;
	logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, mem_req_valid, mem_req_ready;
	logic mem_rsp_valid, work_head, work_valid, done_ready, used_notify;
	logic [1:0] s_bresp, s_rresp;
	logic [31:0] s_rdata;
	logic [127:0] mem_rdata;
	pre_pkg::pre_mem_req_t mem_req;
	pre_pkg::pre_desc_t work_desc;
	logic work_ready = 1'b0, done_valid = 1'b0, uw = 1'b1, sup_wait = 1'b0;
	pre_pkg::pre_done_t done = '0;
	pre_pkg::pre_desc_t exp_work[$];
	logic exp_head[$];
	logic [159:0] exp_used[$];
	int num_errors = 0, checks_done = 0, notifies = 0, sup_done = 0, sup_target = 0, upos = 0, i;

	always #5 aclk = ~aclk;

	pre_engine dut (.aclk(aclk), .aresetn(aresetn), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid),
		.s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid),
		.s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
		.s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rdata(s_rdata),
		.s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready), .mem_req(mem_req),
		.mem_req_valid(mem_req_valid), .mem_req_ready(mem_req_ready),
		.mem_rsp_valid(mem_rsp_valid), .mem_rdata(mem_rdata), .work_desc(work_desc),
		.work_head(work_head), .work_valid(work_valid), .work_ready(work_ready), .done(done),
		.done_valid(done_valid), .done_ready(done_ready), .used_notify(used_notify));
	pre_ring_driver_model #(.RING_BASE(BASE), .RING_SIZE(RSZ)) mdl (.aclk(aclk),
		.aresetn(aresetn), .mem_req(mem_req), .mem_req_valid(mem_req_valid),
		.mem_req_ready(mem_req_ready), .mem_rsp_valid(mem_rsp_valid), .mem_rdata(mem_rdata));

	task automatic print_verdict();
		$display("Checks %0d, errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : print_verdict

	task automatic check(input logic [159:0] seen, input logic [159:0] exp);
		checks_done++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// A wait that ran out ends the run as a failure
	task automatic fail_wait();
		num_errors++;
		print_verdict();
	endtask : fail_wait

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
		int n;
		@(posedge aclk);
		s_awaddr <= a;
		s_awvalid <= 1'b1;
		s_wdata <= v;
		s_wvalid <= 1'b1;
		s_bready <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge aclk);
			if (s_awready) s_awvalid <= 1'b0;
			if (s_wready) s_wvalid <= 1'b0;
			if (s_bvalid) break;
		end
		s_bready <= 1'b0;
		if (n == 100) fail_wait();
		check(s_bresp, er);
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] a, input logic [31:0] ev, input logic [1:0] er);
		int n;
		@(posedge aclk);
		s_araddr <= a;
		s_arvalid <= 1'b1;
		s_rready <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge aclk);
			if (s_arready) s_arvalid <= 1'b0;
			if (s_rvalid) break;
		end
		s_rready <= 1'b0;
		if (n == 100) fail_wait();
		check(s_rdata, ev);
		check(s_rresp, er);
	endtask : axi_rd

	// Offer through the driver model and note what the work port must show
	task automatic give(input logic [15:0] fl, input logic [15:0] id, input logic head);
		pre_pkg::pre_desc_t nd;
		mdl.offer(fl, id, $urandom, {$urandom, $urandom}, nd);
		exp_work.push_back(nd);
		exp_head.push_back(head);
	endtask : give

	task automatic drain();
		int n;
		for (n = 0; n < 1000 && exp_work.size() > 0; n++) @(posedge aclk);
		if (n == 1000) fail_wait();
	endtask : drain

	// Hand one completion over and note the used entry it must write
	task automatic complete(input logic [15:0] id, input logic [31:0] len, input logic wr, int cnt);
		logic [15:0] f;
		int n;
		f = 16'h0;
		f[15] = uw;
		f[7] = uw;
		f[1] = wr;
		exp_used.push_back({BASE + 32'(upos * 16), f, id, wr ? len : 32'h0, 64'h0});
		upos += cnt;
		if (upos >= RSZ) begin
			upos -= RSZ;
			uw = ~uw;
		end
		sup_target++;
		@(posedge aclk);
		done <= '{id, len, wr};
		done_valid <= 1'b1;
		for (n = 0; n < 500; n++) begin
			@(posedge aclk);
			if (done_ready) break;
		end
		done_valid <= 1'b0;
		if (n == 500) fail_wait();
		for (n = 0; n < 500 && sup_done != sup_target; n++) @(posedge aclk);
		if (n == 500) fail_wait();
	endtask : complete

	// Work consumer that stalls at random, and observer of the memory side
	always @(posedge aclk) begin
		work_ready <= ($urandom % 3 != 0);
		if (work_valid && work_ready) begin
			check(work_desc, exp_work.pop_front());
			check(work_head, exp_head.pop_front());
		end
		if (mem_req_valid && mem_req_ready && mem_req.write && !mem_req.word)
			check({mem_req.addr, mem_req.wdata}, exp_used.pop_front());
		if (mem_req_valid && mem_req_ready && mem_req.write && mem_req.word)
			check({mem_req.addr, mem_req.wdata[31:0]}, {32'h200, 32'h1});
		if (mem_req_valid && mem_req_ready && !mem_req.write && mem_req.word)
			sup_wait <= 1'b1;
		if (mem_rsp_valid && sup_wait) begin
			sup_wait <= 1'b0;
			sup_done <= sup_done + 1;
		end
		if (used_notify) notifies <= notifies + 1;
	end

	initial begin
		void'($urandom(32'h4bab));
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		axi_rd(pre_pkg::REG_RING_SIZE, 32'h0000_8000, pre_pkg::RESP_OKAY);
		axi_rd(pre_pkg::REG_STATUS, 32'h0001_8000, pre_pkg::RESP_OKAY);
		axi_rd(8'h40, 32'h0, pre_pkg::RESP_DECERR);
		axi_wr(8'h44, 32'h1, pre_pkg::RESP_DECERR);
		axi_wr(pre_pkg::REG_RING_BASE, BASE, pre_pkg::RESP_OKAY);
		axi_wr(pre_pkg::REG_RING_SIZE, 32'(RSZ), pre_pkg::RESP_OKAY);
		axi_wr(pre_pkg::REG_DRV_AREA, 32'h100, pre_pkg::RESP_OKAY);
		axi_wr(pre_pkg::REG_DEV_AREA, 32'h200, pre_pkg::RESP_OKAY);
		// Only the low byte lane lands; cap of three still fits every list used here
		s_wstrb <= 4'h1;
		axi_wr(pre_pkg::REG_LIST_CAP, 32'h0000_0203, pre_pkg::RESP_OKAY);
		axi_rd(pre_pkg::REG_LIST_CAP, 32'h0000_0003, pre_pkg::RESP_OKAY);
		s_wstrb <= 4'hf;
		axi_wr(pre_pkg::REG_STATUS, 32'hffff_ffff, pre_pkg::RESP_OKAY);
		axi_rd(pre_pkg::REG_RING_SIZE, 32'(RSZ), pre_pkg::RESP_OKAY);
		mdl.mem[32'h100] = 128'h0;
		axi_wr(pre_pkg::REG_CTRL, 32'h1, pre_pkg::RESP_OKAY);
		axi_wr(pre_pkg::REG_DEV_EVENT, 32'h1, pre_pkg::RESP_OKAY);
		// First lap: readable then writable list, two singles, the last at the final slot
		give(16'h0001, 16'h0000, 1'b1);
		give(16'h0002, 16'h0011, 1'b0);
		give(16'h0000, 16'h0022, 1'b1);
		give(16'h0002, 16'h0033, 1'b1);
		drain();
		axi_rd(pre_pkg::REG_STATUS, 32'h0001_0000, pre_pkg::RESP_OKAY);
		complete(16'h0033, 32'h40, 1'b1, 1);
		complete(16'h0011, 32'h55, 1'b0, 2);
		complete(16'h0022, 32'h18, 1'b1, 1);
		axi_rd(pre_pkg::REG_STATUS, 32'h0, pre_pkg::RESP_OKAY);
		// Second lap only once every slot is used again; one event code per completion
		for (i = 0; i < RSZ; i++) give(16'h0002, 16'h0040 + 16'(i), 1'b1);
		drain();
		for (i = 0; i < RSZ; i++) begin
			mdl.mem[32'h100] = {96'h0, 14'h0, 2'(i), 1'b0, 15'(i)};
			complete(16'h0040 + 16'(i), 32'h20, 1'b1, 1);
		end
		axi_rd(pre_pkg::REG_STATUS, 32'h0001_8000, pre_pkg::RESP_OKAY);
		axi_rd(pre_pkg::REG_USED_POS, 32'h0, pre_pkg::RESP_OKAY);
		check(32'(notifies), 32'd5);
		print_verdict();
	end
endmodule : pre_engine_tb_top

// ### testbench/pre_ring_driver_model.sv
// Driver side model: shared memory with random latency plus the offering driver
`timescale 1ns/1ps
module pre_ring_driver_model #(
	parameter logic [31:0] RING_BASE = 32'h0000_1000,
	parameter int RING_SIZE = 4
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire pre_pkg::pre_mem_req_t mem_req,
	input wire logic mem_req_valid,
	output logic mem_req_ready,
	output logic mem_rsp_valid,
	output logic [127:0] mem_rdata
);
	logic [127:0] mem [logic [31:0]];
	pre_pkg::pre_mem_req_t held;
	logic pend = 1'b0;
	int delay = 0;
	logic drv_wrap = 1'b1;
	int drv_pos = 0;

	// Unwritten memory reads as zero, which is never an available slot
	function automatic logic [127:0] peek(input logic [31:0] a);
		return mem.exists(a) ? mem[a] : 128'h0;
	endfunction : peek

	// Driver offers one descriptor at its next slot
	task automatic offer(input logic [15:0] fl, input logic [15:0] id, input logic [31:0] len,
		input logic [63:0] addr, output pre_pkg::pre_desc_t d);
		d = '{fl, id, len, addr};
		d.flags[pre_pkg::OFFERED_MARKER_BIT] = drv_wrap;
		d.flags[pre_pkg::CONSUMED_MARKER_BIT] = ~drv_wrap;
		mem[RING_BASE + 32'(drv_pos * 16)] = d;
		drv_pos++;
		if (drv_pos == RING_SIZE) begin
			drv_pos = 0;
			drv_wrap = ~drv_wrap;
		end
	endtask : offer

	// Random ready and latency; idle data bus scrambles so stale data never looks valid
	always @(posedge aclk) begin
		if (!aresetn) begin
			pend <= 1'b0;
			delay <= 0;
			mem_req_ready <= 1'b0;
			mem_rsp_valid <= 1'b0;
			mem_rdata <= 128'h0;
		end else if (mem_req_valid && mem_req_ready) begin
			held <= mem_req;
			pend <= 1'b1;
			delay <= $urandom % 4;
			mem_req_ready <= 1'b0;
			mem_rdata <= ~mem_rdata;
		end else if (pend && delay > 0) begin
			delay <= delay - 1;
			mem_rdata <= ~mem_rdata;
		end else if (pend) begin
			// Ready stays low until the answer has gone out
			pend <= 1'b0;
			mem_rsp_valid <= 1'b1;
			if (held.write) begin
				mem[held.addr] = held.word ? {96'h0, held.wdata[31:0]} : held.wdata;
				mem_rdata <= ~mem_rdata;
			end else if (held.word)
				mem_rdata <= {96'h0, 32'(peek(held.addr))};
			else
				mem_rdata <= peek(held.addr);
		end else begin
			mem_req_ready <= ($urandom % 2 == 0);
			mem_rsp_valid <= 1'b0;
			mem_rdata <= ~mem_rdata;
		end
	end
endmodule : pre_ring_driver_model
